// *** etc_cfg.svh ***
// etc_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by the exposure trigger control files, 10 MHz hclk
`ifndef ETC_CFG_SVH
`define ETC_CFG_SVH

`define ETC_CLK_MHZ          10
`define ETC_CLK_PERIOD_NS    100
`define ETC_US_NS            1000
// cycles per microsecond tick, derived from the clock period
`define ETC_US_CYCLES        (`ETC_US_NS / `ETC_CLK_PERIOD_NS)
`define ETC_EXP_MIN_US       16
`define ETC_EXP_MAX_US       60000000
`define ETC_LINE_TIME_US     4

// register byte offsets
`define ETC_OFF_CTRL         12'h000
`define ETC_OFF_EXPTIME      12'h004
`define ETC_OFF_HEIGHT       12'h008
`define ETC_OFF_FRATE        12'h00c
`define ETC_OFF_CMD          12'h010
`define ETC_OFF_STATUS       12'h014
`define ETC_OFF_FRAMES       12'h018

// control field positions
`define ETC_CTRL_TRIG_ON     0
`define ETC_CTRL_SRC_LO      1
`define ETC_CTRL_RISING      3
`define ETC_CTRL_WIDTH_MODE  4
`define ETC_CTRL_USER_OUT    5

// command bits (write one to act)
`define ETC_CMD_ACQ_START    0
`define ETC_CMD_ACQ_STOP     1
`define ETC_CMD_SOFT_TRIG    2

// reset values
`define ETC_CTRL_RST         32'h0000_0008
`define ETC_EXPTIME_RST      32'h0000_03e8
`define ETC_HEIGHT_RST       32'h0000_0800
`define ETC_FRATE_RST        32'h0000_2710

`endif

// *** etc_pkg.sv ***
// etc_pkg.sv: types for the exposure trigger control block
// assumes: constants come from etc_cfg.svh
package etc_pkg;

    typedef enum logic [1:0] {
        SRC_SOFT  = 2'b00,
        SRC_USER  = 2'b01,
        SRC_CC1   = 2'b10,
        SRC_LINE  = 2'b11
    } etc_src_e;

    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_TIMED  = 2'b01,
        ST_WIDTH  = 2'b10
    } etc_exp_e;

    // msb first, so trig_on lands on bit 0 of the control word
    typedef struct packed {
        logic      user_out;
        logic      width_mode;
        logic      rising;
        etc_src_e  src;
        logic      trig_on;
    } etc_ctrl_s;

    typedef struct packed {
        logic        exposing;
        logic        reading;
        logic        waiting;
        logic        acq_run;
    } etc_stat_s;

endpackage : etc_pkg

// *** etc_sync_edge.sv ***
// etc_sync_edge.sv: two-flop synchroniser with edge detection for one pin
// assumes: input is asynchronous to hclk; pulses last at least 3 cycles
`timescale 1ns/1ps
`include "etc_cfg.svh"

module etc_sync_edge (
    input  wire logic hclk,       // system clock
    input  wire logic hresetn,    // async reset, active low
    input  wire logic async_in,   // raw pin level
    output logic      level,      // synchronised level
    output logic      rise,       // one-cycle rising pulse
    output logic      fall        // one-cycle falling pulse
);
    logic [2:0] sh_reg;
    logic [2:0] sh_next;

    // shift chain; first flop is read only by the second
    always_comb begin
        sh_next = {sh_reg[1:0], async_in};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_reg <= 3'h0;
        end else begin
            sh_reg <= sh_next;
        end
    end

    // edges compare flop two against flop three, one detection per edge
    assign level = sh_reg[1];
    assign rise  = sh_reg[1] & ~sh_reg[2];
    assign fall  = ~sh_reg[1] & sh_reg[2];
endmodule : etc_sync_edge

// *** etc_exposure_ctrl.sv ***
// etc_exposure_ctrl.sv: exposure start and duration control with AHB-Lite registers
// assumes: single AHB-Lite master, whole-word single transfers, 10 MHz hclk
// Contract
// - external line edge triggers when selected
// - activation picks rising or falling edge
// - waiting state starts acquisition on edge
// - leave waiting, ignore edges while busy
// - return to waiting automatically
// - timed and trigger-width modes offered
// - timed mode holds exposure time setting
// - timed mode drops edges during exposure
// - width rising: expose until input falls
// - width falling: expose until input rises
// - timed length when off, software, timed
// - exposure time counted in microseconds
// - width mode has no upper bound
// - readout follows exposure end
// - new exposure overlaps previous readout
// - readout time scales with frame height
// - free run between start and stop
// - source select: soft, user, cc1, line
`timescale 1ns/1ps
`include "etc_cfg.svh"

module etc_exposure_ctrl (
    input  wire logic        hclk,          // bus and block clock
    input  wire logic        hresetn,       // async reset, active low
    input  wire logic        hsel,          // slave select
    input  wire logic [11:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write when high
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic        hready,        // bus ready in
    input  wire logic [31:0] hwdata,        // write data
    output logic      [31:0] hrdata,        // read data
    output logic             hreadyout,     // slave ready
    output logic             hresp,         // always okay
    input  wire logic        external_trigger_line, // external trigger pin
    input  wire logic        cc1_line,      // frame grabber control line
    output logic             exposure_active, // sensor integrating
    output logic             readout_start,   // one-cycle readout start pulse
    output logic             readout_busy,    // readout in progress
    output logic             wait_trigger     // waiting for exposure start
);
    etc_pkg::etc_ctrl_s ctrl_reg, ctrl_next;
    logic [31:0] exp_reg, exp_next, height_reg, height_next, frate_reg, frate_next;
    logic [31:0] frames_reg, frames_next;
    logic        acq_reg, acq_next;
    logic        soft_reg, soft_next;
    logic [31:0] hrdata_next;
    logic        ph_wr_reg, ph_wr_next;
    logic [11:0] ph_addr_reg, ph_addr_next;

    // address phase capture; zero wait states so hreadyout stays high
    logic take;
    assign take = hsel & hready & htrans[1];

    always_comb begin
        ph_wr_next   = take & hwrite;
        ph_addr_next = take ? haddr : ph_addr_reg;
    end

    // trigger pin synchronisers
    logic line_lvl, line_rise, line_fall, cc1_lvl, cc1_rise, cc1_fall;

    etc_sync_edge u_sync_line (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (external_trigger_line),
        .level    (line_lvl),
        .rise     (line_rise),
        .fall     (line_fall)
    );

    etc_sync_edge u_sync_cc1 (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (cc1_line),
        .level    (cc1_lvl),
        .rise     (cc1_rise),
        .fall     (cc1_fall)
    );

    // user output toggle edges, same domain, no sync needed
    logic user_d_reg, user_d_next;
    assign user_d_next = ctrl_reg.user_out;

    logic src_lvl, src_rise, src_fall, src_start, src_end, ext_src;
    always_comb begin
        src_lvl  = 1'b0;
        src_rise = 1'b0;
        src_fall = 1'b0;
        case (ctrl_reg.src)
            etc_pkg::SRC_SOFT: begin
                src_rise = soft_reg;
            end
            etc_pkg::SRC_USER: begin
                src_lvl  = ctrl_reg.user_out;
                src_rise = ctrl_reg.user_out & ~user_d_reg;
                src_fall = ~ctrl_reg.user_out & user_d_reg;
            end
            etc_pkg::SRC_CC1: begin
                src_lvl  = cc1_lvl;
                src_rise = cc1_rise;
                src_fall = cc1_fall;
            end
            default: begin
                src_lvl  = line_lvl;
                src_rise = line_rise;
                src_fall = line_fall;
            end
        endcase
    end
    assign src_start = (ctrl_reg.rising || ctrl_reg.src == etc_pkg::SRC_SOFT)
                       ? src_rise : src_fall;
    assign src_end   = ctrl_reg.rising ? src_fall : src_rise;
    assign ext_src   = ctrl_reg.src != etc_pkg::SRC_SOFT;

    logic [3:0] pre_reg, pre_next;
    logic       us_tick;
    assign us_tick = (pre_reg == 4'(`ETC_US_CYCLES - 1));
    assign pre_next = us_tick ? 4'h0 : pre_reg + 4'h1;

    logic [31:0] fr_cnt_reg, fr_cnt_next;
    logic        free_start;

    // exposure state machine
    etc_pkg::etc_exp_e st_reg, st_next;
    logic [31:0] ecnt_reg, ecnt_next;
    logic        start_now, exp_done;

    always_comb begin
        fr_cnt_next = fr_cnt_reg;
        free_start  = 1'b0;
        if (!acq_reg || ctrl_reg.trig_on) begin
            fr_cnt_next = 32'h0;
        end else if (us_tick) begin
            if (fr_cnt_reg >= frate_reg - 32'h1) begin
                fr_cnt_next = 32'h0;
                free_start  = 1'b1;
            end else begin
                fr_cnt_next = fr_cnt_reg + 32'h1;
            end
        end
    end

    // edge starts acquisition only when waiting
    assign start_now = (st_reg == etc_pkg::ST_WAIT) &&
                       (ctrl_reg.trig_on ? (acq_reg & src_start) : free_start);

    always_comb begin
        st_next   = st_reg;
        ecnt_next = ecnt_reg;
        exp_done  = 1'b0;
        case (st_reg)
            etc_pkg::ST_WAIT: begin
                if (start_now) begin
                    ecnt_next = 32'h0;
                    if (ctrl_reg.trig_on && ext_src && ctrl_reg.width_mode) begin
                        st_next = etc_pkg::ST_WIDTH;
                    end else begin
                        st_next = etc_pkg::ST_TIMED;
                    end
                end
            end
            etc_pkg::ST_TIMED: begin
                if (us_tick) begin
                    ecnt_next = ecnt_reg + 32'h1;
                    if (ecnt_reg + 32'h1 >= exp_reg) begin
                        st_next  = etc_pkg::ST_WAIT;
                        exp_done = 1'b1;
                    end
                end
            end
            etc_pkg::ST_WIDTH: begin
                // no bound, pulse alone ends it
                if (src_end) begin
                    st_next  = etc_pkg::ST_WAIT;
                    exp_done = 1'b1;
                end
            end
            default: begin
                st_next = etc_pkg::ST_WAIT;
            end
        endcase
    end
    // edges ignored outside wait; auto return to wait

    // readout after exposure; length scales with height
    logic [31:0] rd_cnt_reg, rd_cnt_next;
    logic        rd_busy_reg, rd_busy_next, rd_pend_reg, rd_pend_next;
    logic        rd_go;
    // exposure overlaps readout; a done during readout waits its turn
    always_comb begin
        rd_pend_next = rd_pend_reg | exp_done;
        rd_go        = 1'b0;
        rd_busy_next = rd_busy_reg;
        rd_cnt_next  = rd_cnt_reg;
        if (rd_busy_reg) begin
            if (us_tick) begin
                if (rd_cnt_reg >= height_reg * `ETC_LINE_TIME_US - 32'h1) begin
                    rd_busy_next = 1'b0;
                end else begin
                    rd_cnt_next = rd_cnt_reg + 32'h1;
                end
            end
        end else if (rd_pend_reg) begin
            rd_go        = 1'b1;
            rd_pend_next = exp_done;
            rd_busy_next = 1'b1;
            rd_cnt_next  = 32'h0;
        end
    end

    // register writes and commands
    always_comb begin
        ctrl_next   = ctrl_reg;
        exp_next    = exp_reg;
        height_next = height_reg;
        frate_next  = frate_reg;
        acq_next    = acq_reg;
        soft_next   = 1'b0;
        frames_next = frames_reg + {31'h0, exp_done};
        if (ph_wr_reg) begin
            if (ph_addr_reg == `ETC_OFF_CTRL) begin
                ctrl_next = etc_pkg::etc_ctrl_s'(hwdata[5:0]);
            end else if (ph_addr_reg == `ETC_OFF_EXPTIME) begin
                exp_next = hwdata;
            end else if (ph_addr_reg == `ETC_OFF_HEIGHT) begin
                height_next = hwdata;
            end else if (ph_addr_reg == `ETC_OFF_FRATE) begin
                frate_next = hwdata;
            end else if (ph_addr_reg == `ETC_OFF_CMD) begin
                if (hwdata[`ETC_CMD_ACQ_START]) acq_next = 1'b1;
                if (hwdata[`ETC_CMD_ACQ_STOP])  acq_next = 1'b0;
                soft_next = hwdata[`ETC_CMD_SOFT_TRIG];
            end
        end
    end

    // read data, registered so it stands in the data phase
    always_comb begin
        hrdata_next = 32'h0;
        if (take && !hwrite) begin
            if (haddr == `ETC_OFF_CTRL) begin
                hrdata_next = {26'h0, ctrl_reg};
            end else if (haddr == `ETC_OFF_EXPTIME) begin
                hrdata_next = exp_reg;
            end else if (haddr == `ETC_OFF_HEIGHT) begin
                hrdata_next = height_reg;
            end else if (haddr == `ETC_OFF_FRATE) begin
                hrdata_next = frate_reg;
            end else if (haddr == `ETC_OFF_STATUS) begin
                hrdata_next = {28'h0, st_reg != etc_pkg::ST_WAIT, rd_busy_reg,
                               st_reg == etc_pkg::ST_WAIT, acq_reg};
            end else if (haddr == `ETC_OFF_FRAMES) begin
                hrdata_next = frames_reg;
            end
        end
    end

    // state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg    <= etc_pkg::etc_ctrl_s'(6'(`ETC_CTRL_RST));
            exp_reg     <= `ETC_EXPTIME_RST;
            height_reg  <= `ETC_HEIGHT_RST;
            frate_reg   <= `ETC_FRATE_RST;
            frames_reg  <= 32'h0;
            acq_reg     <= 1'b0;
            soft_reg    <= 1'b0;
            user_d_reg  <= 1'b0;
            ph_wr_reg   <= 1'b0;
            ph_addr_reg <= 12'h0;
            hrdata      <= 32'h0;
            pre_reg     <= 4'h0;
            fr_cnt_reg  <= 32'h0;
            st_reg      <= etc_pkg::ST_WAIT;
            ecnt_reg    <= 32'h0;
            rd_cnt_reg  <= 32'h0;
            rd_busy_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            exp_reg     <= exp_next;
            height_reg  <= height_next;
            frate_reg   <= frate_next;
            frames_reg  <= frames_next;
            acq_reg     <= acq_next;
            soft_reg    <= soft_next;
            user_d_reg  <= user_d_next;
            ph_wr_reg   <= ph_wr_next;
            ph_addr_reg <= ph_addr_next;
            hrdata      <= hrdata_next;
            pre_reg     <= pre_next;
            fr_cnt_reg  <= fr_cnt_next;
            st_reg      <= st_next;
            ecnt_reg    <= ecnt_next;
            rd_cnt_reg  <= rd_cnt_next;
            rd_busy_reg <= rd_busy_next;
            rd_pend_reg <= rd_pend_next;
        end
    end

    // output flops load the next state, so they match the state they mirror; readout_start follows rd_go one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exposure_active <= 1'b0;
            readout_start   <= 1'b0;
            readout_busy    <= 1'b0;
            wait_trigger    <= 1'b1;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
        end else begin
            exposure_active <= st_next != etc_pkg::ST_WAIT;
            readout_start   <= rd_go;
            readout_busy    <= rd_busy_next;
            wait_trigger    <= st_next == etc_pkg::ST_WAIT;
            hreadyout       <= 1'b1;
            hresp           <= 1'b0;
        end
    end
endmodule : etc_exposure_ctrl

// *** etc_exposure_ctrl_chk.sv ***
// etc_exposure_ctrl_chk.sv: port assertions for the exposure trigger control block
// assumes: bound to every etc_exposure_ctrl instance, a single clock domain
`timescale 1ns/1ps
module etc_exposure_ctrl_chk (
    input wire logic        hclk,            // block clock
    input wire logic        hresetn,         // async reset, active low
    input wire logic        hsel,            // slave select
    input wire logic [1:0]  htrans,          // transfer type
    input wire logic        hwrite,          // write when high
    input wire logic        hready,          // bus ready in
    input wire logic [31:0] hrdata,          // read data
    input wire logic        hreadyout,       // slave ready
    input wire logic        hresp,           // response
    input wire logic        exposure_active, // sensor integrating
    input wire logic        readout_start,   // readout start pulse
    input wire logic        readout_busy,    // readout running
    input wire logic        wait_trigger     // waiting for a start
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // read address phase taken this cycle
    logic rd_ap;
    assign rd_ap = hsel && hready && htrans[1] && !hwrite;

    // exposure ends while the readout engine is free
    sequence s_exp_end;
        $fell(exposure_active) ##0 !readout_busy;
    endsequence
    sequence s_rd_go;
        ##[0:2] readout_start;
    endsequence

    property p_ready;
        hreadyout == 1'b1;
    endproperty
    a_ready: assert property (p_ready) else $error("hreadyout low");

    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");

    property p_rdata_idle;
        !rd_ap |=> hrdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("hrdata not zero");

    property p_excl;
        !(wait_trigger && exposure_active);
    endproperty
    a_excl: assert property (p_excl) else $error("waiting while exposing");

    property p_start;
        $rose(exposure_active) |-> $past(wait_trigger);
    endproperty
    a_start: assert property (p_start) else $error("start without waiting");

    property p_launch;
        s_exp_end |-> s_rd_go;
    endproperty
    a_launch: assert property (p_launch) else $error("readout not launched");

    property p_pulse;
        readout_start |=> !readout_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("readout start too long");

    property p_busy;
        readout_start |-> ##[0:1] readout_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("readout busy missing");

    property p_rewait;
        $fell(exposure_active) |-> ##[0:3] wait_trigger;
    endproperty
    a_rewait: assert property (p_rewait) else $error("no return to waiting");
endmodule : etc_exposure_ctrl_chk

bind etc_exposure_ctrl etc_exposure_ctrl_chk chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite,
    .hready, .hrdata, .hreadyout, .hresp, .exposure_active, .readout_start, .readout_busy,
    .wait_trigger);

// *** etc_trig_src.sv ***
// etc_trig_src.sv: trigger source model driving the external line and cc1
// assumes: bench raises go for one cycle; pins change on the falling clock edge
`timescale 1ns/1ps
module etc_trig_src (
    input  wire logic        hclk,                  // bench clock
    input  wire logic        go,                    // start one pulse
    input  wire logic        on_cc1,                // pulse cc1, not the line
    input  wire logic        rising,                // active level is high
    input  wire logic [15:0] hold,                  // active length in cycles
    output logic             external_trigger_line, // external pin
    output logic             cc1_line               // grabber control line
);
    logic [15:0] cnt = 16'h0;

    // one pulse only
    // a go during a running pulse is dropped; changes land away from sampling
    always @(negedge hclk) begin
        if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
        end else if (go) begin
            cnt <= hold;
        end
    end

    // idle pins rest at the inactive level, so only the active edge can start
    assign external_trigger_line = (!on_cc1 && cnt != 16'h0) ? rising : !rising;
    assign cc1_line = (on_cc1 && cnt != 16'h0) ? rising : !rising;
endmodule : etc_trig_src

// *** etc_exposure_ctrl_test.sv ***
// etc_exposure_ctrl_test.sv: self-checking bench for the exposure trigger control block
// assumes: etc_trig_src drives both trigger pins; 100 ns clock
`timescale 1ns/1ps
`include "etc_cfg.svh"
module etc_exposure_ctrl_test;
    logic        hclk, hreadyout, hresp, xline, cc1, exp_act, rd_start, rd_busy, waiting;
    logic        hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic        on_cc1 = 1'b0, rising = 1'b1;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [11:0] haddr = 12'h000;
    logic [15:0] hold = 16'h0;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    int          err_count, n_compared, len, gap, t;

    etc_exposure_ctrl dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .external_trigger_line(xline), .cc1_line(cc1), .exposure_active(exp_act),
        .readout_start(rd_start), .readout_busy(rd_busy), .wait_trigger(waiting));
    etc_trig_src src_u (.hclk, .go, .on_cc1, .rising, .hold,
        .external_trigger_line(xline), .cc1_line(cc1));

    // 10 MHz clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // watchdog: the whole run needs well under 10000 cycles
    initial begin
        repeat (30000) @(posedge hclk);
        err_count++;
        give_verdict();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rng(input int got, input int lo, input int hi);
        n_compared++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask : rng

    // one AHB-Lite single transfer; hready is the slave's own hreadyout
    task automatic bus(input logic wr_en, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr_en;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    // waits for an exposure, then measures how many cycles it stands
    task automatic expose(input int lo, input int hi);
        gap = 0;
        while (exp_act !== 1'b1 && gap < 600) begin
            @(posedge hclk);
            gap++;
        end
        chk(32'(waiting), 32'h0);
        len = 0;
        while (exp_act === 1'b1 && len < 4000) begin
            @(posedge hclk);
            len++;
        end
        rng(len, lo, hi);
    endtask : expose

    task automatic quiet(input int n);
        int hits;
        hits = 0;
        repeat (n) begin
            @(posedge hclk);
            if (exp_act !== 1'b0) hits++;
        end
        chk(32'(hits), 32'h0);
    endtask : quiet

    // waits until readout is over and the block waits again
    task automatic settle();
        t = 0;
        while ((rd_busy !== 1'b0 || waiting !== 1'b1) && t < 2000) begin
            @(posedge hclk);
            t++;
        end
        chk(32'(rd_busy), 32'h0);
    endtask : settle

    task automatic pulse(input logic c, input int h);
        @(posedge hclk);
        on_cc1 <= c;
        hold <= 16'(h);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
    endtask : pulse

    // idle level swaps; call only after the control word ignores that edge
    task automatic pol(input logic r);
        @(posedge hclk);
        rising <= r;
        repeat (10) @(posedge hclk);
    endtask : pol

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // exposure 16 us = 160 cycles; readout 4 lines x 4 us = 160 cycles
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'(waiting), 32'h1);
        rdc(`ETC_OFF_CTRL, `ETC_CTRL_RST);
        rdc(`ETC_OFF_EXPTIME, `ETC_EXPTIME_RST);
        rdc(`ETC_OFF_HEIGHT, `ETC_HEIGHT_RST);
        rdc(`ETC_OFF_FRATE, `ETC_FRATE_RST);
        rdc(`ETC_OFF_STATUS, 32'h2);
        wr(12'h020, 32'hffff_ffff);
        rdc(12'h020, 32'h0);
        wr(`ETC_OFF_EXPTIME, 32'h10);
        wr(`ETC_OFF_HEIGHT, 32'h4);
        rdc(`ETC_OFF_EXPTIME, 32'h10);
        wr(`ETC_OFF_CMD, 32'h1);
        $display("test registers done");
        wr(`ETC_OFF_CTRL, 32'h0f);
        fork
            expose(150, 161);
            begin
                pulse(1'b0, 5);
                repeat (60) @(posedge hclk);
                pulse(1'b0, 5);
            end
        join
        quiet(60);
        chk(32'(rd_busy), 32'h1);
        settle();
        rng(t, 90, 103);
        $display("test timed line done");
        wr(`ETC_OFF_CTRL, 32'h05);
        pol(1'b0);
        pulse(1'b1, 250);
        expose(150, 161);
        quiet(150);
        settle();
        wr(`ETC_OFF_CTRL, 32'h15);
        pulse(1'b1, 300);
        expose(298, 302);
        settle();
        $display("test falling cc1 done");
        wr(`ETC_OFF_CTRL, 32'h1f);
        pol(1'b1);
        pulse(1'b0, 40);
        expose(38, 42);
        pulse(1'b0, 200);
        repeat (5) @(posedge hclk);
        chk(32'(exp_act), 32'h1);
        chk(32'(rd_busy), 32'h1);
        expose(185, 200);
        settle();
        $display("test width overlap done");
        wr(`ETC_OFF_CTRL, 32'h09);
        wr(`ETC_OFF_CMD, 32'h4);
        expose(150, 161);
        settle();
        wr(`ETC_OFF_CTRL, 32'h0b);
        wr(`ETC_OFF_CTRL, 32'h2b);
        expose(150, 161);
        settle();
        wr(`ETC_OFF_CTRL, 32'h0b);
        quiet(30);
        $display("test soft and user done");
        wr(`ETC_OFF_FRATE, 32'h28);
        wr(`ETC_OFF_CTRL, 32'h08);
        expose(150, 161);
        expose(150, 161);
        rng(gap, 225, 252);
        wr(`ETC_OFF_CMD, 32'h2);
        quiet(500);
        rdc(`ETC_OFF_STATUS, 32'h2);
        rdc(`ETC_OFF_FRAMES, 32'h9);
        $display("test free run done");
        give_verdict();
    end
endmodule : etc_exposure_ctrl_test
